// File: inc/stc_defs.vh
`ifndef STC_DEFS_VH
`define STC_DEFS_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define STC_ADDR_W 8
`define STC_OFFS_CFG1 8'h9A
`define STC_RST_CFG1 32'h00000000
`define STC_RW_MASK 32'h80C7FF8F
`define STC_RST_RDATA 32'h00000000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define STC_PARITY_BIT 31
`define STC_XFER_HI 23
`define STC_XFER_LO 22
`define STC_NEG_HI 18
`define STC_NEG_LO 16
`define STC_HYST_BIT 15
`define STC_BEMF_HI 14
`define STC_BEMF_LO 10
`define STC_CYC_HI 9
`define STC_CYC_LO 7
`define STC_ANG_HI 3
`define STC_ANG_LO 2
`define STC_DIV_HI 1
`define STC_DIV_LO 0

// ----------------------------------------------------------------------
// decoded constants
// ----------------------------------------------------------------------
`define STC_XFER_BASE 5'h03
`define STC_BEMF_STEP 13'h00C8
`define STC_CYC_BASE 5'h02
`define STC_CYC_STEP 5'h03
`define STC_HYST_WIDE 7'h14
`define STC_HYST_NARROW 7'h0A
`define STC_RST_NEG 7'h00
`define STC_RST_BEMF 13'h0000
`define STC_RST_ANG 4'h5
`define STC_RST_DIV 4'h1

`endif

// File: logic/stc_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.vh"

// ----------------------------------------------------------------------
// field decode to working values
// ----------------------------------------------------------------------
module stc_decode (
  input wire [31:0] cfg_in,
  output reg [4:0] xfer_cycles_out,
  output reg signed [6:0] neg_limit_out,
  output reg signed [6:0] hyst_out,
  output reg signed [6:0] pos_limit_out,
  output reg [12:0] bemf_thr_out,
  output reg [4:0] cyc_thr_out,
  output reg [3:0] angle_deg_out,
  output reg [3:0] div_factor_out
);
  reg [2:0] neg_code;
  always @* begin
    neg_code = cfg_in[`STC_NEG_HI:`STC_NEG_LO];
    xfer_cycles_out = `STC_XFER_BASE <<
      cfg_in[`STC_XFER_HI:`STC_XFER_LO];
    case (neg_code)
      3'h0: neg_limit_out = 7'sh00;
      3'h1: neg_limit_out = -7'sd40;
      3'h2: neg_limit_out = -7'sd30;
      3'h3: neg_limit_out = -7'sd20;
      3'h4: neg_limit_out = -7'sd10;
      3'h5: neg_limit_out = 7'sd10;
      3'h6: neg_limit_out = 7'sd20;
      default: neg_limit_out = 7'sd30;
    endcase
    hyst_out = cfg_in[`STC_HYST_BIT] ? `STC_HYST_NARROW :
      `STC_HYST_WIDE;
    pos_limit_out = hyst_out + neg_limit_out;
    bemf_thr_out = `STC_BEMF_STEP *
      {8'h00, cfg_in[`STC_BEMF_HI:`STC_BEMF_LO]};
    cyc_thr_out = `STC_CYC_BASE + `STC_CYC_STEP *
      {2'h0, cfg_in[`STC_CYC_HI:`STC_CYC_LO]};
    case (cfg_in[`STC_ANG_HI:`STC_ANG_LO])
      2'h0: angle_deg_out = 4'h5;
      2'h1: angle_deg_out = 4'h8;
      2'h2: angle_deg_out = 4'hC;
      default: angle_deg_out = 4'hF;
    endcase
    div_factor_out = 4'h1 << cfg_in[`STC_DIV_HI:`STC_DIV_LO];
  end
endmodule
`default_nettype wire

// File: logic/stc_trap_cfg.v
// What this block does
// - the register sits at byte offset 9Ah and resets to all zeros.
// - bits 23-22 pick 3, 6, 12 or 24 open-to-closed transfer cycles.
// - bits 18-16 pick the surge guard negative limit 0,-40..-10,10..30.
// - bit 15 picks hysteresis 20 or 10; positive limit is sum of both.
// - bits 14-10 give back-EMF threshold 200*code; 9-7 give 2+3*code.
// - bits 3-2 pick open-loop crossing angle 5, 8, 12 or 15 degrees.
// - bits 1-0 pick quick launch divider 1, 2, 4 or 8.
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.vh"

module stc_trap_cfg (
  input wire mclk_in,
  input wire rst_b_in,
  input wire [7:0] addr_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [31:0] wdata_in,
  output reg [31:0] rdata_out,
  output reg [31:0] cfg_out,
  output reg [4:0] open_to_closed_transfer_cycles_out,
  output reg [6:0] surge_guard_negative_limit_out,
  output reg [6:0] surge_guard_hysteresis_out,
  output reg [6:0] surge_guard_positive_limit_out,
  output reg [12:0] spin_detect_backemf_threshold_out,
  output reg [4:0] spin_detect_cycle_threshold_out,
  output reg [3:0] open_loop_crossing_angle_out,
  output reg [3:0] quick_launch_rate_divider_out
);
  // --------------------------------------------------------------------
  // state and wiring
  // --------------------------------------------------------------------
  reg [31:0] cfg_q;
  reg [31:0] cfg_d;
  reg [31:0] rdata_d;
  wire wr_hit;
  wire rd_hit;
  wire [4:0] xfer_d;
  wire [6:0] neg_d;
  wire [6:0] hyst_d;
  wire [6:0] pos_d;
  wire [12:0] bemf_d;
  wire [4:0] cyc_d;
  wire [3:0] ang_d;
  wire [3:0] div_d;

  // --------------------------------------------------------------------
  // levels shown during reset
  // --------------------------------------------------------------------
  localparam [31:0] rdata_rst = `STC_RST_RDATA;
  localparam [31:0] cfg_rst = `STC_RST_CFG1;
  localparam [4:0] xfer_rst = `STC_XFER_BASE;
  localparam [6:0] neg_rst = `STC_RST_NEG;
  localparam [6:0] hyst_rst = `STC_HYST_WIDE;
  localparam [6:0] pos_rst = `STC_HYST_WIDE;
  localparam [12:0] bemf_rst = `STC_RST_BEMF;
  localparam [4:0] cyc_rst = `STC_CYC_BASE;
  localparam [3:0] ang_rst = `STC_RST_ANG;
  localparam [3:0] div_rst = `STC_RST_DIV;

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  function addr_hit(input [7:0] addr);
    addr_hit = addr == `STC_OFFS_CFG1;
  endfunction

  assign wr_hit = wr_en_in && addr_hit(addr_in);
  assign rd_hit = rd_en_in && addr_hit(addr_in);

  // --------------------------------------------------------------------
  // write path
  // --------------------------------------------------------------------
  always @* begin
    cfg_d = cfg_q;
    if (wr_hit) begin
      cfg_d = wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cfg_q <= `STC_RST_CFG1;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  always @* begin
    rdata_d = rdata_rst;
    if (rd_hit) begin
      rdata_d = cfg_q;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rdata_out <= rdata_rst;
    end else begin
      rdata_out <= rdata_d;
    end
  end

  // --------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------
  stc_decode u_dec (
    .cfg_in(cfg_q),
    .xfer_cycles_out(xfer_d),
    .neg_limit_out(neg_d),
    .hyst_out(hyst_d),
    .pos_limit_out(pos_d),
    .bemf_thr_out(bemf_d),
    .cyc_thr_out(cyc_d),
    .angle_deg_out(ang_d),
    .div_factor_out(div_d)
  );

  // --------------------------------------------------------------------
  // register copy
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cfg_out <= cfg_rst;
    end else begin
      cfg_out <= cfg_q;
    end
  end

  // --------------------------------------------------------------------
  // transfer cycle count
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      open_to_closed_transfer_cycles_out <= xfer_rst;
    end else begin
      open_to_closed_transfer_cycles_out <= xfer_d;
    end
  end

  // --------------------------------------------------------------------
  // surge guard negative limit
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      surge_guard_negative_limit_out <= neg_rst;
    end else begin
      surge_guard_negative_limit_out <= neg_d;
    end
  end

  // --------------------------------------------------------------------
  // surge guard hysteresis
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      surge_guard_hysteresis_out <= hyst_rst;
    end else begin
      surge_guard_hysteresis_out <= hyst_d;
    end
  end

  // --------------------------------------------------------------------
  // surge guard positive limit
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      surge_guard_positive_limit_out <= pos_rst;
    end else begin
      surge_guard_positive_limit_out <= pos_d;
    end
  end

  // --------------------------------------------------------------------
  // spin detect back-emf threshold
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      spin_detect_backemf_threshold_out <= bemf_rst;
    end else begin
      spin_detect_backemf_threshold_out <= bemf_d;
    end
  end

  // --------------------------------------------------------------------
  // spin detect cycle threshold
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      spin_detect_cycle_threshold_out <= cyc_rst;
    end else begin
      spin_detect_cycle_threshold_out <= cyc_d;
    end
  end

  // --------------------------------------------------------------------
  // open loop crossing angle
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      open_loop_crossing_angle_out <= ang_rst;
    end else begin
      open_loop_crossing_angle_out <= ang_d;
    end
  end

  // --------------------------------------------------------------------
  // quick launch rate divider
  // --------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      quick_launch_rate_divider_out <= div_rst;
    end else begin
      quick_launch_rate_divider_out <= div_d;
    end
  end
endmodule
`default_nettype wire

// File: testbench/stc_trap_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module stc_trap_cfg_checker (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [31:0] wdata_in,
  input wire logic [31:0] rdata_out,
  input wire logic [31:0] cfg_out,
  input wire logic [4:0] open_to_closed_transfer_cycles_out,
  input wire logic [6:0] surge_guard_negative_limit_out,
  input wire logic [6:0] surge_guard_hysteresis_out,
  input wire logic [6:0] surge_guard_positive_limit_out,
  input wire logic [12:0] spin_detect_backemf_threshold_out,
  input wire logic [4:0] spin_detect_cycle_threshold_out,
  input wire logic [3:0] open_loop_crossing_angle_out,
  input wire logic [3:0] quick_launch_rate_divider_out
);
  // ----------------
  // port checks
  // ----------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic wh, rh;
  logic [2:0] nc;
  int nv;
  assign wh = wr_en_in && addr_in == 8'h9A;
  assign rh = rd_en_in && addr_in == 8'h9A;
  assign nc = cfg_out[18:16];
  assign nv = nc == 0 ? 0 : 10 * nc - (nc < 5 ? 50 : 40);
  sequence lone_wr; wh ##1 !wh; endsequence
  a_write_lands: assert property (lone_wr |-> ##1
    cfg_out == $past(wdata_in, 2)) else $error("write lost");
  a_read_data: assert property (rh |=> rdata_out == cfg_out)
    else $error("bad read");
  a_idle_zero: assert property (!rh |=> rdata_out == 32'h0)
    else $error("rdata not 0");
  a_xfer_count: assert property (
    open_to_closed_transfer_cycles_out == (5'h03 << cfg_out[23:22]))
    else $error("bad xfer");
  a_neg_limit: assert property (
    $signed(surge_guard_negative_limit_out) == nv) else $error("bad neg");
  a_hyst_pos: assert property (
    surge_guard_hysteresis_out == (cfg_out[15] ? 7'h0A : 7'h14) &&
    surge_guard_positive_limit_out ==
    surge_guard_negative_limit_out + surge_guard_hysteresis_out)
    else $error("bad hyst");
  a_spin_thr: assert property (
    spin_detect_backemf_threshold_out == 200 * cfg_out[14:10] &&
    spin_detect_cycle_threshold_out == 2 + 3 * cfg_out[9:7])
    else $error("bad spin");
  a_angle_div: assert property (
    open_loop_crossing_angle_out ==
    5 + 3 * cfg_out[3:2] + (cfg_out[3:2] > 1) &&
    quick_launch_rate_divider_out == 1 << cfg_out[1:0])
    else $error("bad angle");
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------
  // bench
  // ----------------
  logic mclk_in = 0, rst_b_in = 0, wr_en_in = 0, rd_en_in = 0;
  logic [7:0] addr_in = 8'h9A;
  logic [31:0] wdata_in = 32'h0, rdata_out, cfg_out, d;
  logic [4:0] open_to_closed_transfer_cycles_out;
  logic [4:0] spin_detect_cycle_threshold_out;
  logic [6:0] surge_guard_negative_limit_out, surge_guard_hysteresis_out;
  logic [6:0] surge_guard_positive_limit_out;
  logic [12:0] spin_detect_backemf_threshold_out;
  logic [3:0] open_loop_crossing_angle_out, quick_launch_rate_divider_out;
  int fails = 0, total_checks = 0;
  logic [31:0] r;
  stc_trap_cfg DUT (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .addr_in(addr_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .wdata_in(wdata_in),
    .rdata_out(rdata_out),
    .cfg_out(cfg_out),
    .open_to_closed_transfer_cycles_out(open_to_closed_transfer_cycles_out),
    .surge_guard_negative_limit_out(surge_guard_negative_limit_out),
    .surge_guard_hysteresis_out(surge_guard_hysteresis_out),
    .surge_guard_positive_limit_out(surge_guard_positive_limit_out),
    .spin_detect_backemf_threshold_out(spin_detect_backemf_threshold_out),
    .spin_detect_cycle_threshold_out(spin_detect_cycle_threshold_out),
    .open_loop_crossing_angle_out(open_loop_crossing_angle_out),
    .quick_launch_rate_divider_out(quick_launch_rate_divider_out)
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] v, output logic [31:0] q);
    wr_en_in = w;
    rd_en_in = !w;
    addr_in = a;
    wdata_in = v;
    @(negedge mclk_in);
    q = rdata_out;
    wr_en_in = 0;
    rd_en_in = 0;
    @(negedge mclk_in);
  endtask
  task automatic t_reset;
    rst_b_in = 0;
    repeat (2) @(negedge mclk_in);
    rst_b_in = 1;
    chk(cfg_out, 32'h0);
    chk(open_to_closed_transfer_cycles_out, 32'h3);
    chk(surge_guard_hysteresis_out, 32'd20);
    acc(0, 8'h9A, 32'h0, r);
    chk(r, 32'h0);
  endtask
  task automatic t_codes;
    int ang[4] = '{5, 8, 12, 15};
    int neg[8] = '{0, -40, -30, -20, -10, 10, 20, 30};
    int h;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], 7'h0, i[1:0], 3'h0, i[2:0], ~i[0], i[1:0], i[2:0], i[2:0],
        3'h0, i[1:0], ~i[1:0]};
      acc(1, 8'h9A, d, r);
      acc(0, 8'h9A, 32'h0, r);
      chk(r, d);
      chk(cfg_out, d);
      chk(open_to_closed_transfer_cycles_out, 32'h3 << i[1:0]);
      chk(surge_guard_negative_limit_out, neg[i][6:0]);
      h = i[0] ? 20 : 10;
      chk(surge_guard_hysteresis_out, h);
      h = h + neg[i];
      chk(surge_guard_positive_limit_out, h[6:0]);
      chk(spin_detect_backemf_threshold_out,
        200 * {i[1:0], i[2:0]});
      chk(spin_detect_cycle_threshold_out, 2 + 3 * i);
      chk(open_loop_crossing_angle_out, ang[i[1:0]]);
      chk(quick_launch_rate_divider_out, 32'h1 << ~i[1:0]);
    end
  endtask
  task automatic t_miss;
    acc(1, 8'h9B, 32'hFFFFFFFF, r);
    acc(0, 8'h9B, 32'h0, r);
    chk(r, 32'h0);
    acc(0, 8'h9A, 32'h0, r);
    chk(r, d);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #5 mclk_in = ~mclk_in;
  initial begin
    #20000;
    fails++;
    wrap_up();
  end
  initial begin
    t_reset();
    t_codes();
    t_miss();
    t_reset();
    wrap_up();
  end
endmodule
bind stc_trap_cfg stc_trap_cfg_checker chk_i (.*);
`default_nettype wire
